// file: hw/guard_pkg.sv
// Constants, types and decode helpers for the protected register write guard.
// Assumes an 8-bit byte-addressed Avalon-MM slave window with one register per aligned word.
package guard_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register map (byte addresses)
  localparam logic [7:0] CMD_OFFSET = 8'h00;
  localparam logic [7:0] SYS_STATUS_OFFSET = 8'h04;
  localparam logic [7:0] IRQ_STATUS_OFFSET = 8'h08;
  localparam logic [7:0] IRQ_MASK_OFFSET = 8'h0C;
  localparam logic [7:0] PROT_BASE = 8'h10;
  localparam logic [7:0] PROT_END = 8'h2C;
  localparam int PROT_COUNT = 7;

  // Protected register order: power save, clock select, processor clock,
  // clock monitor, reset cause, low voltage, debug mode
  localparam logic [55:0] PROT_RESET = {8'h01, 8'h00, 8'h00, 8'h00, 8'h03, 8'h0A, 8'h00};

  ////////////////////////////////////////////////////////////////////////////
  // Field positions and reset values
  localparam int ERR_BIT = 0;
  localparam int IRQ_ILLEGAL_BIT = 0;
  localparam int IRQ_DONE_BIT = 1;
  localparam logic SYS_STATUS_RESET = 1'b0;
  localparam logic [1:0] IRQ_STATUS_RESET = 2'h0;
  localparam logic [1:0] IRQ_MASK_RESET = 2'h0;

  ////////////////////////////////////////////////////////////////////////////
  // Types
  typedef enum logic [1:0]
  {
    BIT_OP_NONE = 2'h0,
    BIT_OP_SET = 2'h1,
    BIT_OP_CLEAR = 2'h2,
    BIT_OP_INVERT = 2'h3
  } bit_op_type;

  typedef enum logic [1:0]
  {
    GUARD_LOCKED = 2'b01,
    GUARD_ARMED = 2'b10
  } guard_state_type;

  ////////////////////////////////////////////////////////////////////////////
  // Helpers
  function automatic logic is_prot(input logic [7:0] a);
    return (a >= PROT_BASE) && (a < PROT_END) && (a[1:0] == 2'h0);
  endfunction

  function automatic logic [2:0] prot_index(input logic [7:0] a);
    logic [7:0] d;
    d = a - PROT_BASE;
    return d[4:2];
  endfunction

  // Plain store, or single-bit set/clear/invert using wdata[2:0] as bit number
  function automatic logic [7:0] apply_write(input logic [7:0] old, input logic [31:0] wdata,
                                             input bit_op_type op);
    logic [7:0] m;
    m = 8'h01 << wdata[2:0];
    unique case (op)
      BIT_OP_NONE: return wdata[7:0];
      BIT_OP_SET: return old | m;
      BIT_OP_CLEAR: return old & ~m;
      BIT_OP_INVERT: return old ^ m;
    endcase
  endfunction

endpackage

// file: hw/guard_if.sv
// Classified register writes and the guard's answer, between the bus slave and the sequencer.
// Both ends run on the same clock.
`timescale 1ns/10ps
interface guard_if;
  logic cmd_wr;
  logic prot_wr;
  logic other_wr;
  logic flag_clear_wr;
  logic accept;
  logic error_set;
  logic armed;

  modport ctrl
  (
    output cmd_wr,
    output prot_wr,
    output other_wr,
    output flag_clear_wr,
    input accept,
    input error_set,
    input armed
  );

  modport seq
  (
    input cmd_wr,
    input prot_wr,
    input other_wr,
    input flag_clear_wr,
    output accept,
    output error_set,
    output armed
  );
endinterface

// file: hw/guard_sequencer.sv
// Lock/arm sequencer deciding whether a protected store is accepted.
// Expects at most one classified write per cycle from the bus slave.
`timescale 1ns/10ps
module guard_sequencer
  import guard_pkg::*;
(
  input wire logic clock,
  input wire logic resetn,
  guard_if.seq g
);

  guard_state_type state_r;
  guard_state_type state_nxt;
  logic any_wr;

  assign any_wr = g.cmd_wr | g.prot_wr | g.other_wr;

  ////////////////////////////////////////////////////////////////////////////
  // Decision
  always_comb
  begin
    state_nxt = state_r;
    unique case (state_r)
      GUARD_LOCKED:
      begin
        if (g.cmd_wr)
        begin
          state_nxt = GUARD_ARMED;
        end
      end
      GUARD_ARMED:
      begin
        // Reads leave the arm in place; any write spends it
        if (any_wr)
        begin
          state_nxt = GUARD_LOCKED;
        end
      end
      default:
      begin
        state_nxt = GUARD_LOCKED;
      end
    endcase
  end

  assign g.accept = (state_r == GUARD_ARMED) && g.prot_wr;
  // Second command store while armed counts as an illegal store
  assign g.error_set = ((state_r == GUARD_LOCKED) && g.prot_wr) ||
                       ((state_r == GUARD_ARMED) && (g.other_wr || g.cmd_wr));
  assign g.armed = state_r[1];

  always_ff @(posedge clock)
  begin
    if (!resetn)
    begin
      state_r <= GUARD_LOCKED;
    end
    else
    begin
      state_r <= state_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking @(posedge clock); endclocking
  default disable iff (!resetn);

  a_arm_any_value: assert property (!g.armed && g.cmd_wr |=> g.armed)
    else $error("command store did not arm the guard");
  a_single_write_arm: assert property (g.armed && any_wr |=> !g.armed)
    else $error("arm survived a write");
  a_read_keeps_arm: assert property (g.armed && !any_wr |=> g.armed)
    else $error("arm lost without a write");
endmodule

// file: hw/protected_register_write_guard.sv
// Avalon-MM slave holding seven protected control registers behind an unlock store.
// Assumes the master holds each request until it samples waitrequest low.
//
// Overview of operation
// - Exactly seven registers are protected: power save, clock select, processor clock, clock monitor, reset cause, low voltage and debug mode.
// - A protected store takes effect only directly after a command register store; otherwise the register keeps its value.
// - The unlocked store may be a plain store or a single-bit set, clear or invert.
// - Every illegal store attempt on protected registers sets the protection error flag.
// - A command register store holds off interrupt acknowledgement until the next store.
// - Protected registers read back with no unlocking.
// - Any value stored to the command register arms a locked guard; the value is ignored.
// - The command register is 8-bit write-only, reads undefined (here zero), and has no reset value.
// - The error flag sets on an unlocked protected store or on any other store right after a command store, except a 0 store to the status register.
// - Plain reads between the command store and the protected store neither set the flag nor cancel the arm.
// - The error flag clears on a 0 store or reset; a 0 store right after a command store clears it, a second command store sets it.
`timescale 1ns/10ps
module protected_register_write_guard
  import guard_pkg::*;
(
  input wire logic clock,
  input wire logic resetn,
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  input wire logic [1:0] bit_op,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic [55:0] protected_values,
  output logic int_hold,
  output logic irq
);

  guard_if g();

  logic wait_r;
  logic [31:0] readdata_r;
  logic [55:0] prot_r;
  logic err_r;
  logic err_nxt;
  logic [1:0] irq_status_r;
  logic [1:0] irq_status_nxt;
  logic [1:0] irq_mask_r;
  logic [1:0] irq_mask_nxt;
  logic irq_r;
  logic acc_wr;
  logic acc_rd;
  logic addr_prot;
  logic [5:0] sel_lsb;
  logic [7:0] sel_old;
  logic [7:0] sel_new;
  logic [7:0] sys_new;
  logic sys_new_bit;
  bit_op_type op;

  ////////////////////////////////////////////////////////////////////////////
  // Bus handshake: one wait cycle, access takes effect when waitrequest is low
  assign acc_wr = avs_write && !wait_r && avs_byteenable[0];
  assign acc_rd = avs_read && !wait_r;
  assign op = bit_op_type'(bit_op);

  always_ff @(posedge clock)
  begin
    if (!resetn)
    begin
      wait_r <= 1'b1;
    end
    else if ((avs_read || avs_write) && wait_r)
    begin
      wait_r <= 1'b0;
    end
    else
    begin
      wait_r <= 1'b1;
    end
  end

  function automatic logic [31:0] read_mux(input logic [7:0] a);
    logic [31:0] v;
    v = 32'h0000_0000;
    if (a == SYS_STATUS_OFFSET)
    begin
      v[ERR_BIT] = err_r;
    end
    else if (a == IRQ_STATUS_OFFSET)
    begin
      v[1:0] = irq_status_r;
    end
    else if (a == IRQ_MASK_OFFSET)
    begin
      v[1:0] = irq_mask_r;
    end
    else if (is_prot(a))
    begin
      v[7:0] = prot_r[{prot_index(a), 3'b000} +: 8];
    end
    // Command register and unmapped words read as zero
    return v;
  endfunction

  always_ff @(posedge clock)
  begin
    if (!resetn)
    begin
      readdata_r <= 32'h0000_0000;
    end
    else if (avs_read && wait_r)
    begin
      readdata_r <= read_mux(avs_address);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Store classification
  assign addr_prot = is_prot(avs_address);
  assign sel_lsb = {prot_index(avs_address), 3'b000};
  assign sel_old = prot_r[sel_lsb +: 8];
  assign sel_new = apply_write(sel_old, avs_writedata, op);
  assign sys_new = apply_write({7'h00, err_r}, avs_writedata, op);
  assign sys_new_bit = sys_new[ERR_BIT];

  assign g.cmd_wr = acc_wr && (avs_address == CMD_OFFSET);
  assign g.prot_wr = acc_wr && addr_prot;
  assign g.other_wr = acc_wr && (avs_address != CMD_OFFSET) && !addr_prot;
  assign g.flag_clear_wr = acc_wr && (avs_address == SYS_STATUS_OFFSET) && !sys_new_bit;

  guard_sequencer u_seq
  (
    .clock(clock),
    .resetn(resetn),
    .g(g)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Protected registers
  always_ff @(posedge clock)
  begin
    if (!resetn)
    begin
      prot_r <= PROT_RESET;
    end
    else if (g.accept)
    begin
      prot_r[sel_lsb +: 8] <= sel_new;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Error flag: a zero store wins over a coincident set, as the hardware defines
  always_comb
  begin
    err_nxt = err_r;
    if (g.flag_clear_wr)
    begin
      err_nxt = 1'b0;
    end
    else if (g.error_set)
    begin
      err_nxt = 1'b1;
    end
  end

  always_ff @(posedge clock)
  begin
    if (!resetn)
    begin
      err_r <= SYS_STATUS_RESET;
    end
    else
    begin
      err_r <= err_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt status, mask and line; a new event wins over the read clear
  always_comb
  begin
    irq_status_nxt = irq_status_r;
    if (acc_rd && (avs_address == IRQ_STATUS_OFFSET))
    begin
      irq_status_nxt = 2'h0;
    end
    if (g.error_set)
    begin
      irq_status_nxt[IRQ_ILLEGAL_BIT] = 1'b1;
    end
    if (g.accept)
    begin
      irq_status_nxt[IRQ_DONE_BIT] = 1'b1;
    end
  end

  always_ff @(posedge clock)
  begin
    if (!resetn)
    begin
      irq_status_r <= IRQ_STATUS_RESET;
      irq_r <= 1'b0;
    end
    else
    begin
      irq_status_r <= irq_status_nxt;
      // Next mask too, so that unmasking a pending bit raises the line without a cycle of lag
      irq_r <= |(irq_status_nxt & irq_mask_nxt);
    end
  end

  always_comb
  begin
    irq_mask_nxt = irq_mask_r;
    if (acc_wr && (avs_address == IRQ_MASK_OFFSET))
    begin
      irq_mask_nxt = avs_writedata[1:0];
    end
  end

  always_ff @(posedge clock)
  begin
    if (!resetn)
    begin
      irq_mask_r <= IRQ_MASK_RESET;
    end
    else
    begin
      irq_mask_r <= irq_mask_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs
  assign avs_waitrequest = wait_r;
  assign avs_readdata = readdata_r;
  assign protected_values = prot_r;
  // Armed state is itself a flop; it holds interrupts off until the next store
  assign int_hold = g.armed;
  assign irq = irq_r;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking @(posedge clock); endclocking
  default disable iff (!resetn);

  sequence s_cmd_store;
    g.cmd_wr && !g.armed;
  endsequence

  sequence s_prot_store_locked;
    g.prot_wr && !g.armed;
  endsequence

  sequence s_guarded_store;
    g.prot_wr && g.armed;
  endsequence

  a_wait_one_cycle: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("waitrequest not released after one cycle");

  a_unlocked_store_dropped: assert property (s_prot_store_locked |=> $stable(prot_r) && err_r)
    else $error("locked protected store changed a register");

  a_guarded_store_lands: assert property (s_guarded_store
                                          |=> 8'(prot_r >> $past(sel_lsb)) == $past(sel_new))
    else $error("guarded store not applied");

  a_error_on_stray: assert property (g.armed && g.other_wr && !g.flag_clear_wr |=> err_r)
    else $error("stray store after command did not flag");

  a_error_on_illegal: assert property (g.error_set && !g.flag_clear_wr
                                       |=> err_r && irq_status_r[IRQ_ILLEGAL_BIT])
    else $error("illegal store not reported");

  a_hold_after_cmd: assert property (s_cmd_store |=> int_hold)
    else $error("interrupts not held after command store");

  a_zero_store_wins: assert property (g.armed && g.flag_clear_wr |=> !err_r)
    else $error("zero store after command did not clear the flag");

  a_cmd_reads_zero: assert property (avs_read && wait_r && avs_address == CMD_OFFSET
                                     |=> avs_readdata == 32'h0000_0000)
    else $error("command register read not zero");

  a_prot_read_free: assert property (avs_read && wait_r && addr_prot
                                     |=> avs_readdata[7:0] == $past(sel_old) && !int_hold == !$past(int_hold))
    else $error("protected read wrong or disturbed the guard");

  a_reset_locked: assert property ($past(!resetn) |-> !int_hold && !err_r && !irq)
    else $error("guard not locked after reset");

  a_irq_level: assert property (irq == |(irq_status_r & irq_mask_r))
    else $error("interrupt line does not follow unmasked status");

  a_flag_sticky: assert property (err_r && !g.flag_clear_wr |=> err_r)
    else $error("error flag dropped without a zero store");

  a_read_keeps_flag: assert property (acc_rd |=> $stable(err_r))
    else $error("read changed the error flag");

  a_cmd_keeps_values: assert property (g.cmd_wr |=> $stable(prot_r))
    else $error("command store changed a protected register");
endmodule

// file: testbench/cpu_store_master.sv
// Partner model: the CPU core issuing peripheral register loads and stores over Avalon-MM.
// Assumes the guard answers each request with one cycle of waitrequest low.
`timescale 1ns/10ps
module cpu_store_master
  import guard_pkg::*;
(
  input wire logic clock,
  input wire logic resetn,
  input wire logic go,
  input wire logic go_write,
  input wire logic [7:0] go_addr,
  input wire logic [31:0] go_data,
  input wire logic [1:0] go_op,
  input wire logic avs_waitrequest,
  input wire logic [31:0] avs_readdata,
  output logic [7:0] avs_address,
  output logic avs_read,
  output logic avs_write,
  output logic [31:0] avs_writedata,
  output logic [1:0] bit_op,
  output logic done,
  output logic [31:0] rdata
);
  // Same source value for the unlock and the guarded store comes from the caller
  always_ff @(posedge clock)
  begin
    if (!resetn)
    begin
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      done <= 1'b0;
    end
    else
    begin
      done <= 1'b0;
      if ((avs_read || avs_write) && !avs_waitrequest)
      begin
        // Released lines show a changing pattern, never the old value
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        avs_address <= ~avs_address;
        avs_writedata <= ~avs_writedata;
        rdata <= avs_readdata;
        done <= 1'b1;
      end
      else if (go && !avs_read && !avs_write)
      begin
        avs_read <= !go_write;
        avs_write <= go_write;
        avs_address <= go_addr;
        avs_writedata <= go_data;
        bit_op <= go_op;
      end
    end
  end
endmodule

// file: testbench/testbench.sv
// Self-checking bench for the protected register write guard.
// Assumes the partner model in cpu_store_master and a 50 ns clock.
`timescale 1ns/10ps
module testbench
  import guard_pkg::*;
;
  logic clock = 1'b0;
  logic resetn = 1'b0;
  logic go = 1'b0;
  logic go_write = 1'b0;
  logic [7:0] go_addr = 8'h00;
  logic [31:0] go_data = 32'h0;
  logic [1:0] go_op = 2'h0;
  logic [7:0] avs_address;
  logic avs_read, avs_write, avs_waitrequest, done, int_hold, irq;
  logic [31:0] avs_writedata, avs_readdata, rdata;
  logic [1:0] bit_op;
  logic [55:0] protected_values;
  int err_count = 0;
  int n_tests = 0;
  logic [31:0] seed = 32'hED234AC2;
  logic [7:0] prot [7];
  logic armed = 1'b0;
  logic err = 1'b0;

  initial forever #25 clock = ~clock;

  cpu_store_master cpu_u (.clock(clock), .resetn(resetn), .go(go), .go_write(go_write), .go_addr(go_addr),
    .go_data(go_data), .go_op(go_op), .avs_waitrequest(avs_waitrequest), .avs_readdata(avs_readdata),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .bit_op(bit_op), .done(done), .rdata(rdata));
  // Byte lane 0 always enabled: every register lives there
  protected_register_write_guard dut_u (.clock(clock), .resetn(resetn), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hF),
    .bit_op(bit_op), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .protected_values(protected_values), .int_hold(int_hold), .irq(irq));

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] rnd();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed;
  endfunction

  function automatic logic [7:0] calc(input logic [7:0] o, input logic [31:0] d, input logic [1:0] op);
    logic [7:0] m;
    m = 8'h01 << d[2:0];
    case (op)
      2'h1: return o | m;
      2'h2: return o & ~m;
      2'h3: return o ^ m;
      default: return d[7:0];
    endcase
  endfunction

  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      err_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic [1:0] op,
                     output logic [31:0] q);
    int n;
    go <= 1'b1;
    go_write <= wr;
    go_addr <= a;
    go_data <= d;
    go_op <= op;
    @(posedge clock);
    go <= 1'b0;
    n = 0;
    do
    begin
      @(posedge clock);
      #1;
      n++;
    end
    while (done !== 1'b1 && n < 20);
    chk(done, 1'b1);
    q = rdata;
  endtask

  task automatic store(input logic [7:0] a, input logic [31:0] d, input logic [1:0] op);
    logic [31:0] q;
    bus(1'b1, a, d, op, q);
    if (a == CMD_OFFSET)
    begin
      err = err | armed;
      armed = !armed;
    end
    else
    begin
      if (a >= PROT_BASE && a < PROT_END && a[1:0] == 2'h0)
      begin
        if (armed)
          prot[int'(a - PROT_BASE) / 4] = calc(prot[int'(a - PROT_BASE) / 4], d, op);
        else
          err = 1'b1;
      end
      else if (a == SYS_STATUS_OFFSET)
        err = (d[0] == 1'b0) ? 1'b0 : (err | armed);
      else
        err = err | armed;
      armed = 1'b0;
    end
  endtask

  task automatic check_state();
    logic [31:0] q;
    bus(1'b0, SYS_STATUS_OFFSET, 32'h0, 2'h0, q);
    chk(q, {31'h0, err});
    chk(int_hold, armed);
    for (int i = 0; i < PROT_COUNT; i++)
      chk(protected_values[i*8 +: 8], prot[i]);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    #250000;
    err_count++;
    finish_test();
  end

  initial
  begin
    logic [31:0] d, q;
    logic [7:0] a;
    repeat (8) @(posedge clock);
    resetn <= 1'b1;
    @(posedge clock);
    #1;
    for (int i = 0; i < PROT_COUNT; i++)
      prot[i] = PROT_RESET[i*8 +: 8];
    check_state();
    for (int i = 0; i < PROT_COUNT; i++)
    begin
      store(PROT_BASE + 8'(4 * i), rnd(), 2'h0);
      check_state();
    end
    store(SYS_STATUS_OFFSET, 32'h0, 2'h0);
    check_state();
    for (int i = 0; i < 2 * PROT_COUNT; i++)
    begin
      a = PROT_BASE + 8'(4 * (i % PROT_COUNT));
      d = rnd();
      store(CMD_OFFSET, d, 2'h0);
      chk(int_hold, 1'b1);
      if (i % 2 == 1)
        bus(1'b0, SYS_STATUS_OFFSET, 32'h0, 2'h0, q);
      chk(int_hold, 1'b1);
      store(a, d, 2'(i % 4));
      check_state();
      // Software gap after a power-save store; DMA is not modelled here
      if (a == PROT_BASE)
        repeat (5) @(posedge clock);
    end
    for (int i = 0; i < PROT_COUNT; i++)
    begin
      bus(1'b0, PROT_BASE + 8'(4 * i), 32'h0, 2'h0, q);
      chk(q, {24'h0, prot[i]});
    end
    store(CMD_OFFSET, rnd(), 2'h0);
    store(8'h40, rnd(), 2'h0);
    store(PROT_BASE, rnd(), 2'h0);
    check_state();
    store(CMD_OFFSET, 32'h0, 2'h0);
    store(PROT_END, 32'h1, 2'h0);
    check_state();
    store(SYS_STATUS_OFFSET, 32'h0, 2'h0);
    store(CMD_OFFSET, rnd(), 2'h0);
    store(CMD_OFFSET, rnd(), 2'h0);
    check_state();
    store(CMD_OFFSET, rnd(), 2'h0);
    store(SYS_STATUS_OFFSET, 32'h0, 2'h0);
    check_state();
    bus(1'b0, CMD_OFFSET, 32'h0, 2'h0, q);
    chk(q, 32'h0);
    // Interrupt: unmask illegal only, then raise, read-clear, and a masked done event
    store(IRQ_MASK_OFFSET, 32'h1, 2'h0);
    bus(1'b0, IRQ_STATUS_OFFSET, 32'h0, 2'h0, q);
    store(PROT_BASE + 8'h04, rnd(), 2'h0);
    repeat (2) @(posedge clock);
    #1;
    chk(irq, 1'b1);
    bus(1'b0, IRQ_STATUS_OFFSET, 32'h0, 2'h0, q);
    chk(q, 32'h1);
    store(SYS_STATUS_OFFSET, 32'h0, 2'h0);
    store(CMD_OFFSET, rnd(), 2'h0);
    store(PROT_BASE + 8'h08, rnd(), 2'h0);
    repeat (2) @(posedge clock);
    #1;
    chk(irq, 1'b0);
    bus(1'b0, IRQ_STATUS_OFFSET, 32'h0, 2'h0, q);
    chk(q, 32'h2);
    check_state();
    // Mid-run reset while armed, with the flag and an unmasked interrupt pending
    store(PROT_BASE, rnd(), 2'h0);
    store(CMD_OFFSET, rnd(), 2'h0);
    resetn <= 1'b0;
    repeat (8) @(posedge clock);
    resetn <= 1'b1;
    @(posedge clock);
    #1;
    armed = 1'b0;
    err = 1'b0;
    for (int i = 0; i < PROT_COUNT; i++)
      prot[i] = PROT_RESET[i*8 +: 8];
    chk(int_hold, 1'b0);
    chk(irq, 1'b0);
    check_state();
    finish_test();
  end
endmodule
